// File: design/probe_pkg.sv
// Package: register offsets, field layouts and selector codes of the signal router
package probe_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] SERIAL_SWITCH_ADDR = 8'h00;
   localparam logic [7:0] ANALOG_PROBE_ADDR = 8'h01;
   localparam logic [7:0] DIGITAL_PROBE_ADDR = 8'h02;
   localparam logic [7:0] SERIAL_SWITCH_RESET = 8'h00;
   localparam logic [7:0] ANALOG_PROBE_RESET = 8'h00;
   localparam logic [7:0] DIGITAL_PROBE_RESET = 8'h00;
   // Register fields: serial switch selector and route bit, analog and digital probe code widths
   localparam int SWITCH_SEL_LSB = 0;
   localparam int SWITCH_SEL_W = 3;
   localparam int ROUTE_EN_BIT = 7;
   localparam int ANALOG_CODE_W = 5;
   localparam int DIGITAL_CODE_W = 7;
   // ****************************************
   // Serial switch codes
   // ****************************************
   localparam logic [2:0] SW_LOW = 3'h0;
   localparam logic [2:0] SW_HIGH = 3'h1;
   localparam logic [2:0] SW_MILLER = 3'h2;
   localparam logic [2:0] SW_NRZ = 3'h3;
   localparam logic [2:0] SW_MANCH_SUB = 3'h4;
   localparam logic [2:0] SW_MANCH = 3'h5;
   // ****************************************
   // Analog probe codes
   // ****************************************
   localparam logic [4:0] ANA_LAST_DEFINED = 5'h0c;
   // ****************************************
   // Digital probe codes, full 8-bit register value
   // ****************************************
   localparam logic [7:0] DIG_NONE = 8'h00;
   localparam logic [7:0] DIG_RX_DATA = 8'hf4;
   localparam logic [7:0] DIG_RX_VALID = 8'he4;
   localparam logic [7:0] DIG_RX_COLL = 8'hd4;
   localparam logic [7:0] DIG_SER_CLOCK = 8'hc4;
   localparam logic [7:0] DIG_RD_SYNC = 8'hb5;
   localparam logic [7:0] DIG_WR_SYNC = 8'ha5;
   localparam logic [7:0] DIG_CARRIER_CLK = 8'h96;
   localparam logic [7:0] DIG_PSK_OUT = 8'h83;
   localparam logic [7:0] DIG_PSK_AMPL = 8'he2;
endpackage : probe_pkg

// File: design/test_signal_router.sv
// Observation multiplexer driving the serial observation pin and the analog probe select
`timescale 1ns/1ps
module test_signal_router (
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   input wire logic envelope_in,
   input wire logic tx_nrz_in,
   input wire logic tx_miller_in,
   input wire logic rx_manch_sub_in,
   input wire logic rx_manch_in,
   input wire logic rate_106_typea_in,
   input wire logic rx_data_in,
   input wire logic rx_valid_in,
   input wire logic rx_coll_in,
   input wire logic transmitting_in,
   input wire logic encoder_clk_in,
   input wire logic receiver_clk_in,
   input wire logic rd_sync_in,
   input wire logic wr_sync_in,
   input wire logic carrier_clk_in,
   input wire logic phase_keyed_output_in,
   input wire logic phase_keyed_amplitude_flag_in,
   output logic serial_observe_pin_out,
   output logic [4:0] analog_probe_code_out,
   output logic analog_probe_enable_out
);

   // ****************************************
   // Registers
   // ****************************************
   logic [7:0] switch_q;
   logic [7:0] analog_q;
   logic [7:0] digital_q;
   logic [2:0] serial_switch_selector;
   logic digital_probe_route_enable;
   logic [6:0] digital_probe_code;
   logic switch_bit;
   logic digital_bit;
   logic observe_d;

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         switch_q <= probe_pkg::SERIAL_SWITCH_RESET;
      end else if (reg_wr_in && reg_addr_in == probe_pkg::SERIAL_SWITCH_ADDR) begin
         switch_q <= reg_wdata_in;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         analog_q <= probe_pkg::ANALOG_PROBE_RESET;
      end else if (reg_wr_in && reg_addr_in == probe_pkg::ANALOG_PROBE_ADDR) begin
         analog_q <= reg_wdata_in;
      end
   end

   // Full byte kept: codes are defined as 8-bit register values
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         digital_q <= probe_pkg::DIGITAL_PROBE_RESET;
      end else if (reg_wr_in && reg_addr_in == probe_pkg::DIGITAL_PROBE_ADDR) begin
         digital_q <= reg_wdata_in;
      end
   end

   // Unmapped addresses read zero
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         if (reg_addr_in == probe_pkg::SERIAL_SWITCH_ADDR) begin
            reg_rdata_out <= switch_q;
         end else if (reg_addr_in == probe_pkg::ANALOG_PROBE_ADDR) begin
            reg_rdata_out <= analog_q;
         end else if (reg_addr_in == probe_pkg::DIGITAL_PROBE_ADDR) begin
            reg_rdata_out <= digital_q;
         end else begin
            reg_rdata_out <= 8'h00;
         end
      end else begin
         reg_rdata_out <= 8'h00;
      end
   end

   assign serial_switch_selector = switch_q[probe_pkg::SWITCH_SEL_LSB +: probe_pkg::SWITCH_SEL_W];
   assign digital_probe_route_enable = switch_q[probe_pkg::ROUTE_EN_BIT];
   assign digital_probe_code = digital_q[probe_pkg::DIGITAL_CODE_W-1:0];

   // ****************************************
   // Serial switch
   // ****************************************
   always_comb begin
      switch_bit = 1'b0;
      case (serial_switch_selector)
         probe_pkg::SW_LOW: switch_bit = 1'b0;
         probe_pkg::SW_HIGH: switch_bit = 1'b1;
         probe_pkg::SW_MILLER: switch_bit = tx_miller_in;
         probe_pkg::SW_NRZ: switch_bit = tx_nrz_in;
         // Decoder views only meaningful at the base type A rate
         probe_pkg::SW_MANCH_SUB: switch_bit = rx_manch_sub_in & rate_106_typea_in;
         probe_pkg::SW_MANCH: switch_bit = rx_manch_in & rate_106_typea_in;
         default: switch_bit = 1'b0;
      endcase
   end

   // ****************************************
   // Digital probe select
   // ****************************************
   always_comb begin
      digital_bit = 1'b0;
      case (digital_q)
         probe_pkg::DIG_RX_DATA: digital_bit = rx_data_in;
         probe_pkg::DIG_RX_VALID: digital_bit = rx_valid_in;
         probe_pkg::DIG_RX_COLL: digital_bit = rx_coll_in;
         probe_pkg::DIG_SER_CLOCK: digital_bit = transmitting_in ? encoder_clk_in
                                                                 : receiver_clk_in;
         probe_pkg::DIG_RD_SYNC: digital_bit = rd_sync_in;
         probe_pkg::DIG_WR_SYNC: digital_bit = wr_sync_in;
         probe_pkg::DIG_CARRIER_CLK: digital_bit = carrier_clk_in;
         probe_pkg::DIG_PSK_OUT: digital_bit = phase_keyed_output_in;
         probe_pkg::DIG_PSK_AMPL: digital_bit = phase_keyed_amplitude_flag_in;
         default: digital_bit = 1'b0;
      endcase
   end

   // Code 00h falls back to switch even with the route bit set
   always_comb begin
      if (digital_probe_route_enable && digital_q != probe_pkg::DIG_NONE) begin
         observe_d = digital_bit;
      end else begin
         observe_d = switch_bit;
      end
   end

   // Registered pin: clocks faster than half mclk alias; acceptable for a probe
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         serial_observe_pin_out <= 1'b0;
      end else begin
         serial_observe_pin_out <= observe_d;
      end
   end

   // ****************************************
   // Analog probe select
   // ****************************************
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         analog_probe_code_out <= 5'h00;
         analog_probe_enable_out <= 1'b0;
      end else if (analog_q[probe_pkg::ANALOG_CODE_W-1:0] <= probe_pkg::ANA_LAST_DEFINED) begin
         analog_probe_code_out <= analog_q[probe_pkg::ANALOG_CODE_W-1:0];
         analog_probe_enable_out <= 1'b1;
      end else begin
         analog_probe_code_out <= 5'h00;
         analog_probe_enable_out <= 1'b0;
      end
   end

   logic unused_bits;
   // Envelope view not offered: code 2 carries the Miller stream
   assign unused_bits = ^{digital_probe_code, analog_q[7:5], switch_q[6:3], envelope_in};

endmodule : test_signal_router

// File: verification/test_signal_router_assertions.sv
// Checker for the signal router ports
`timescale 1ns/1ps
module test_signal_router_assertions (
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic tx_nrz_in,
   input wire logic tx_miller_in,
   input wire logic rx_manch_sub_in,
   input wire logic rate_106_typea_in,
   input wire logic rx_data_in,
   input wire logic serial_observe_pin_out,
   input wire logic [4:0] analog_probe_code_out,
   input wire logic analog_probe_enable_out
);
   logic [7:0] sw_q;
   logic [7:0] dg_q;
   logic [4:0] an_q;
   wire logic p = serial_observe_pin_out;
   wire logic en = analog_probe_enable_out;
   // Shadow selectors, updated on the same edge as the registers
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sw_q <= 8'h00;
         dg_q <= 8'h00;
         an_q <= 5'h00;
      end else if (reg_wr_in) begin
         if (reg_addr_in == probe_pkg::SERIAL_SWITCH_ADDR) sw_q <= reg_wdata_in;
         if (reg_addr_in == probe_pkg::DIGITAL_PROBE_ADDR) dg_q <= reg_wdata_in;
         if (reg_addr_in == probe_pkg::ANALOG_PROBE_ADDR) an_q <= reg_wdata_in[4:0];
      end
   end
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_b_in);
   a_nrz_view: assert property (sw_q == 8'h03 |=> p == $past(tx_nrz_in))
      else $error("nrz view wrong");
   a_miller_view: assert property (sw_q == 8'h02 |=> p == $past(tx_miller_in))
      else $error("miller view wrong");
   a_manch_gate: assert property (sw_q == 8'h04 |=>
      p == $past(rx_manch_sub_in & rate_106_typea_in)) else $error("manchester view wrong");
   a_switch_spare: assert property (!sw_q[7] && sw_q[2:1] == 2'h3 |=> !p)
      else $error("spare switch not low");
   a_data_route: assert property (sw_q[7] && dg_q == 8'hf4 |=> p == $past(rx_data_in))
      else $error("data route wrong");
   a_unlisted_low: assert property (sw_q[7] && dg_q == 8'h55 |=> !p)
      else $error("unlisted code not low");
   a_ana_code: assert property (rst_b_in && an_q <= 5'h0c |=>
      en && analog_probe_code_out == $past(an_q))
      else $error("analog code wrong");
   a_ana_spare: assert property (an_q > 5'h0c |=> !en && analog_probe_code_out == 5'h00)
      else $error("reserved analog code selects");
endmodule : test_signal_router_assertions
bind test_signal_router test_signal_router_assertions i_chk (.*);

// File: verification/observe_probe.sv
// Probe model counting rising edges on the observation pin
`timescale 1ns/1ps
module observe_probe (
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic pin_in,
   output logic [7:0] rises_out
);
   logic last_q;
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         last_q <= 1'b0;
         rises_out <= 8'h00;
      end else begin
         last_q <= pin_in;
         if (pin_in && !last_q) rises_out <= rises_out + 8'h01;
      end
   end
endmodule : observe_probe

// File: verification/test_signal_router_test.sv
// Self-checking bench for the signal router
`timescale 1ns/1ps
module test_signal_router_test;
   logic mclk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rate = 1'b1;
   logic txing = 1'b0;
   logic [13:0] sig = 14'h0000;
   logic [7:0] r0;
   wire logic [7:0] rdata, rises;
   wire logic [4:0] acode;
   wire logic pin, aen;
   int n_mismatch = 0;
   int checks = 0;
   // Switch byte, digital byte, index of the signal that should show (e high, f low)
   logic [23:0] rows [20] = '{24'h0000_0f, 24'h0100_0e, 24'h0200_01, 24'h0300_00,
      24'h0400_02, 24'h0500_03, 24'h0600_0f, 24'h0700_0f, 24'h8100_0e, 24'h80f4_04,
      24'h80e4_05, 24'h80d4_06, 24'h81c4_07, 24'h80b5_08, 24'h80a5_09, 24'h8096_0a,
      24'h8083_0b, 24'h80e2_0c, 24'h8155_0f, 24'h01f4_0e};
   test_signal_router i_dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .envelope_in(1'b0), .tx_nrz_in(sig[0]), .tx_miller_in(sig[1]),
      .rx_manch_sub_in(sig[2]), .rx_manch_in(sig[3]), .rate_106_typea_in(rate),
      .rx_data_in(sig[4]), .rx_valid_in(sig[5]), .rx_coll_in(sig[6]),
      .transmitting_in(txing), .encoder_clk_in(sig[13]), .receiver_clk_in(sig[7]),
      .rd_sync_in(sig[8]), .wr_sync_in(sig[9]), .carrier_clk_in(sig[10]),
      .phase_keyed_output_in(sig[11]), .phase_keyed_amplitude_flag_in(sig[12]),
      .serial_observe_pin_out(pin), .analog_probe_code_out(acode),
      .analog_probe_enable_out(aen));
   observe_probe i_probe (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .pin_in(pin),
      .rises_out(rises));
   initial forever #12.5 mclk_in = ~mclk_in;
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic wrr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk_in);
      wr <= 1'b0;
   endtask : wrr
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk_in);
      rd <= 1'b0;
      #1 cmp(rdata, exp);
   endtask : rdc
   // One signal high then all others high, so a wrong pick shows either way
   task automatic see(input logic [3:0] k);
      for (int q = 0; q < 2; q++) begin
         @(posedge mclk_in);
         sig <= (q == 1) ? ~(14'h0001 << k) : (14'h0001 << k);
         repeat (2) @(posedge mclk_in);
         #1 cmp({7'h00, pin}, {7'h00, k == 4'he || (k < 4'he && q == 0)});
      end
   endtask : see
   task automatic give_verdict;
      $display("n_mismatch=%0d checks=%0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : give_verdict
   initial begin
      #100us;
      n_mismatch++;
      give_verdict;
   end
   initial begin
      repeat (8) @(posedge mclk_in);
      rst_b_in <= 1'b1;
      foreach (rows[i]) begin
         wrr(probe_pkg::SERIAL_SWITCH_ADDR, rows[i][23:16]);
         wrr(probe_pkg::DIGITAL_PROBE_ADDR, rows[i][15:8]);
         see(rows[i][3:0]);
      end
      for (int c = 0; c < 32; c++) begin
         wrr(probe_pkg::ANALOG_PROBE_ADDR, 8'(c));
         repeat (2) @(posedge mclk_in);
         #1 cmp({aen, 2'h0, acode}, c < 13 ? {3'h4, 5'(c)} : 8'h00);
      end
      @(posedge mclk_in) rate <= 1'b0;
      wrr(probe_pkg::SERIAL_SWITCH_ADDR, 8'h04);
      see(4'hf);
      @(posedge mclk_in) txing <= 1'b1;
      wrr(probe_pkg::SERIAL_SWITCH_ADDR, 8'h80);
      wrr(probe_pkg::DIGITAL_PROBE_ADDR, 8'hc4);
      see(4'hd);
      wrr(probe_pkg::DIGITAL_PROBE_ADDR, 8'h96);
      for (int i = 0; i < 13; i++) begin
         @(posedge mclk_in);
         sig[10] <= ~sig[10];
         #1;
         if (i == 4) r0 = rises;
         if (i == 12) cmp(rises - r0, 8'h04);
      end
      rdc(probe_pkg::DIGITAL_PROBE_ADDR, 8'h96);
      rdc(8'h03, 8'h00);
      wrr(probe_pkg::DIGITAL_PROBE_ADDR, probe_pkg::DIG_NONE);
      rdc(probe_pkg::DIGITAL_PROBE_ADDR, 8'h00);
      @(posedge mclk_in) rst_b_in <= 1'b0;
      @(posedge mclk_in) rst_b_in <= 1'b1;
      for (int a = 0; a < 3; a++) rdc(8'(a), 8'h00);
      give_verdict;
   end
endmodule : test_signal_router_test
